//--- core/bst_tap.sv
// Boundary-scan test access port: controller, instruction and data registers
//
// Summary of operation
// R01 - Four pins drive controller and registers
// R02 - Mode and data inputs pulled high
// R03 - Test clock input pulled low
// R04 - Sixteen-state controller stepped by mode-select
// R05 - Reset state on reset or five highs
// R06 - Reset loads identification instruction
// R07 - Instruction picks the serial data path
// R08 - External test drives pins from chain
// R09 - Identification selects 32-bit identity register
// R10 - Sample captures chain, pins stay normal
// R11 - Float tristates outputs, bypass path
// R12 - Clamp holds cell values, bypass path
// R13 - All-ones bypass, pins stay normal
// R14 - Cells: shift flop plus update latch
// R15 - Cells capture, shift, update, pass through
// R16 - Chain covers every digital pin
// R17 - Identity fields at their bit ranges
// R18 - Maker field drops parity bit
// R19 - Sample on rise, drive out on fall
// R20 - Test reset asynchronous, system undisturbed; the code samples it through the two-flop synchroniser instead
`timescale 1ns/1ps
`default_nettype none

module bst_tap
  import bst_pkg::*;
#(
  parameter int          NUM_CELLS = 8,
  parameter logic [3:0]  VERSION   = 4'h1,  // Arbitrary value
  parameter logic [15:0] PART_ID   = 16'h1234,  // Arbitrary value
  parameter logic [3:0]  MFR_BANK  = 4'h2,  // Arbitrary value
  parameter logic [7:0]  MFR_CODE  = 8'h35  // Arbitrary value
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  input  wire logic                 trst_b,
  input  wire logic                 tmsOpen,
  input  wire logic                 tdiOpen,
  input  wire logic                 tckOpen,
  output logic                      tdo,
  output logic                      tdoEn,
  input  wire logic [NUM_CELLS-1:0] sysOut,
  input  wire logic [NUM_CELLS-1:0] sysOe,
  input  wire logic [NUM_CELLS-1:0] pinIn,
  output logic      [NUM_CELLS-1:0] pinOut,
  output logic      [NUM_CELLS-1:0] pinOe,
  output logic      [NUM_CELLS-1:0] coreIn,
  output logic                      testMode
);

  // ****************************************
  // Pin conditioning
  // ****************************************
  logic      tmsPin;
  logic      tdiPin;
  logic      tckPin;
  bst_edge_t edges;
  logic      trstSync_b;

  // Weak pulls: open inputs resolve to their pull levels
  assign tmsPin = tmsOpen ? 1'b1 : tms;  // R02
  assign tdiPin = tdiOpen ? 1'b1 : tdi;  // R02
  assign tckPin = tckOpen ? 1'b0 : tck;  // R03

  // All four test input pins enter through the synchroniser
  bst_pin_sync u_sync (  // R01
    .clk        (clk),
    .rst_b      (rst_b),
    .tck        (tckPin),
    .tms        (tmsPin),
    .tdi        (tdiPin),
    .trst_b     (trst_b),
    .edges      (edges),
    .trstSync_b (trstSync_b)
  );

  // ****************************************
  // Controller
  // ****************************************
  bst_state_t state_q;
  bst_state_t state_d;
  logic [2:0] highCnt_q;
  logic       forceRst;

  // Next state from mode-select, taken on the rising test clock
  always_comb begin
    state_d = state_q;
    case (state_q)  // R04
      ST_RESET:    state_d = edges.modeSel ? ST_RESET : ST_IDLE;
      ST_IDLE:     state_d = edges.modeSel ? ST_DR_SEL : ST_IDLE;
      ST_DR_SEL:   state_d = edges.modeSel ? ST_IR_SEL : ST_DR_CAP;
      ST_DR_CAP:   state_d = edges.modeSel ? ST_DR_EXIT1 : ST_DR_SHIFT;
      ST_DR_SHIFT: state_d = edges.modeSel ? ST_DR_EXIT1 : ST_DR_SHIFT;
      ST_DR_EXIT1: state_d = edges.modeSel ? ST_DR_UPD : ST_DR_PAUSE;
      ST_DR_PAUSE: state_d = edges.modeSel ? ST_DR_EXIT2 : ST_DR_PAUSE;
      ST_DR_EXIT2: state_d = edges.modeSel ? ST_DR_UPD : ST_DR_SHIFT;
      ST_DR_UPD:   state_d = edges.modeSel ? ST_DR_SEL : ST_IDLE;
      ST_IR_SEL:   state_d = edges.modeSel ? ST_RESET : ST_IR_CAP;
      ST_IR_CAP:   state_d = edges.modeSel ? ST_IR_EXIT1 : ST_IR_SHIFT;
      ST_IR_SHIFT: state_d = edges.modeSel ? ST_IR_EXIT1 : ST_IR_SHIFT;
      ST_IR_EXIT1: state_d = edges.modeSel ? ST_IR_UPD : ST_IR_PAUSE;
      ST_IR_PAUSE: state_d = edges.modeSel ? ST_IR_EXIT2 : ST_IR_PAUSE;
      ST_IR_EXIT2: state_d = edges.modeSel ? ST_IR_UPD : ST_IR_SHIFT;
      ST_IR_UPD:   state_d = edges.modeSel ? ST_DR_SEL : ST_IDLE;
      default:     state_d = ST_RESET;
    endcase
  end

  // Counts rising edges with both mode-select and data-in high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      highCnt_q <= 3'h0;
    end else if (!trstSync_b) begin
      highCnt_q <= 3'h0;
    end else if (edges.rise) begin
      if (!(edges.modeSel && edges.dataIn)) begin
        highCnt_q <= 3'h0;
      end else if (highCnt_q < FORCE_RESET_PERIODS) begin
        highCnt_q <= highCnt_q + 3'h1;
      end
    end
  end

  // Fifth consecutive high period forces the reset state
  assign forceRst = edges.rise && edges.modeSel && edges.dataIn &&
                    (highCnt_q == FORCE_RESET_PERIODS - 3'h1);  // R05

  // The reset pin goes through the synchroniser, so its effect lags by two clk cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_RESET;  // R05
    end else if (!trstSync_b || forceRst) begin
      state_q <= ST_RESET;  // R20 R05
    end else if (edges.rise) begin
      state_q <= state_d;  // R19
    end
  end

  // ****************************************
  // Instruction register
  // ****************************************
  logic [IR_WIDTH-1:0] irShift_q;
  logic [IR_WIDTH-1:0] ir_q;
  logic                rstState;

  assign rstState = (state_q == ST_RESET);

  // Shift stage captures the fixed pattern, update stage holds the live code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irShift_q <= IR_CAPTURE;
      ir_q      <= INS_IDENT;  // R06
    end else if (rstState) begin
      ir_q <= INS_IDENT;  // R06 R20
    end else if (edges.rise) begin
      case (state_q)
        ST_IR_CAP:   irShift_q <= IR_CAPTURE;
        ST_IR_SHIFT: irShift_q <= {edges.dataIn, irShift_q[IR_WIDTH-1:1]};
        default:     irShift_q <= irShift_q;
      endcase
    end else if (edges.fall && state_q == ST_IR_UPD) begin
      ir_q <= irShift_q;
    end
  end

  // ****************************************
  // Instruction decode
  // ****************************************
  // Decodes which serial path an instruction selects; unknown codes take bypass
  function automatic bst_path_t pathOf(input logic [IR_WIDTH-1:0] code);
    if (code == INS_EXTEST || code == INS_SAMPLE) begin
      pathOf = PATH_CHAIN;  // R08 R10
    end else if (code == INS_IDENT) begin
      pathOf = PATH_IDENT;  // R09
    end else begin
      pathOf = PATH_BYPASS;  // R11 R12 R13
    end
  endfunction

  bst_path_t path;
  logic      drivesPins;
  logic      floatAll;

  assign path       = pathOf(ir_q);  // R07
  assign drivesPins = (ir_q == INS_EXTEST) || (ir_q == INS_CLAMP);  // R08 R12
  assign floatAll   = (ir_q == INS_FLOAT);  // R11

  // ****************************************
  // Data registers
  // ****************************************
  localparam logic [31:0] ID_VALUE = {VERSION, PART_ID, MFR_BANK, MFR_CODE[6:0],
                                      ID_FIXED_ONE};  // R17 R18
  logic [31:0]          idShift_q;
  logic                 bypass_q;
  logic [2*NUM_CELLS-1:0] chainShift_q;
  logic [2*NUM_CELLS-1:0] chainHold_q;
  logic                 drCap;
  logic                 drShift;

  assign drCap   = edges.rise && state_q == ST_DR_CAP;
  assign drShift = edges.rise && state_q == ST_DR_SHIFT;

  // Identity and bypass shifters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idShift_q <= 32'h0;
      bypass_q  <= 1'b0;
    end else if (drCap) begin
      idShift_q <= ID_VALUE;  // R09 R17
      bypass_q  <= 1'b0;
    end else if (drShift) begin
      idShift_q <= {edges.dataIn, idShift_q[31:1]};
      bypass_q  <= edges.dataIn;
    end
  end

  // Chain: one output cell and one enable cell per pin; capture takes the pin
  // level into the output cells and the core enable into the enable cells
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chainShift_q <= '0;
    end else if (path == PATH_CHAIN && drCap) begin
      chainShift_q <= {sysOe, pinIn};  // R15 R16
    end else if (path == PATH_CHAIN && drShift) begin
      chainShift_q <= {edges.dataIn, chainShift_q[2*NUM_CELLS-1:1]};  // R14 R15
    end
  end

  // Update stage moves only in the update state; power-up reset clears it, test reset leaves it holding
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chainHold_q <= '0;
    end else if (edges.fall && state_q == ST_DR_UPD && path == PATH_CHAIN) begin
      chainHold_q <= chainShift_q;  // R14 R15
    end
  end

  // ****************************************
  // Pin muxing
  // ****************************************
  // Registered so every pin output comes from a flop; adds one clk of lag
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut   <= '0;
      pinOe    <= '0;
      coreIn   <= '0;
      testMode <= 1'b0;
    end else begin
      coreIn   <= pinIn;  // R15
      testMode <= drivesPins;
      if (floatAll) begin
        pinOut <= sysOut;
        pinOe  <= '0;  // R11
      end else if (drivesPins) begin
        pinOut <= chainHold_q[NUM_CELLS-1:0];  // R08 R12
        pinOe  <= chainHold_q[2*NUM_CELLS-1:NUM_CELLS];
      end else begin
        pinOut <= sysOut;  // R09 R10 R13 R20
        pinOe  <= sysOe;
      end
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  logic serialBit;

  // Picks the low bit of whichever register is in the path
  always_comb begin
    serialBit = bypass_q;
    if (state_q == ST_IR_SHIFT) begin
      serialBit = irShift_q[0];
    end else if (path == PATH_IDENT) begin
      serialBit = idShift_q[0];
    end else if (path == PATH_CHAIN) begin
      serialBit = chainShift_q[0];
    end
  end

  // Output changes on the falling test clock, driven only while shifting
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo   <= 1'b0;
      tdoEn <= 1'b0;
    end else if (edges.fall) begin
      tdo   <= serialBit;  // R19
      tdoEn <= (state_q == ST_IR_SHIFT) || (state_q == ST_DR_SHIFT);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_reset_loads_ident: assert property (@(posedge clk) disable iff (!rst_b)
    rstState |=> ir_q == INS_IDENT)  // R06
    else $error("Reset state did not load identification code");

  a_trst_forces_reset: assert property (@(posedge clk) disable iff (!rst_b)
    !trstSync_b |=> state_q == ST_RESET)  // R20
    else $error("Test reset did not force reset state");

  a_five_highs_reset: assert property (@(posedge clk) disable iff (!rst_b)
    forceRst |=> state_q == ST_RESET)  // R05
    else $error("Five high periods did not reset controller");

  a_state_on_rise: assert property (@(posedge clk) disable iff (!rst_b)
    (!edges.rise && trstSync_b && !forceRst && !rstState) |=> $stable(state_q))  // R04
    else $error("Controller moved without a rising test clock");

  a_tdo_on_fall: assert property (@(posedge clk) disable iff (!rst_b)
    !edges.fall |=> $stable(tdo))  // R19
    else $error("Serial output changed off the falling edge");

  a_float_outputs: assert property (@(posedge clk) disable iff (!rst_b)
    floatAll |=> pinOe == '0)  // R11
    else $error("Float instruction left an output enabled");

  a_extest_drives: assert property (@(posedge clk) disable iff (!rst_b)
    (ir_q == INS_EXTEST) |=> pinOut == $past(chainHold_q[NUM_CELLS-1:0]))  // R08
    else $error("External test not driving cell values");

  a_normal_pass: assert property (@(posedge clk) disable iff (!rst_b)
    (ir_q == INS_BYPASS || ir_q == INS_SAMPLE) |=> pinOut == $past(sysOut))  // R13
    else $error("Normal instruction did not pass system value");

  a_hold_on_update: assert property (@(posedge clk) disable iff (!rst_b)
    !(edges.fall && state_q == ST_DR_UPD) |=> $stable(chainHold_q))  // R14
    else $error("Update latch changed outside update");

  a_ident_capture: assert property (@(posedge clk) disable iff (!rst_b)
    drCap |=> idShift_q[0] == 1'b1 && idShift_q[31:28] == VERSION)  // R17
    else $error("Identity capture value wrong");

endmodule
`default_nettype wire

//--- shared/bst_pkg.sv
// Package of constants and types for the boundary-scan test port
package bst_pkg;

  // ****************************************
  // Instruction codes
  // ****************************************
  localparam int          IR_WIDTH    = 16;
  localparam logic [15:0] INS_EXTEST  = 16'hffe8;
  localparam logic [15:0] INS_IDENT   = 16'hfffe;
  localparam logic [15:0] INS_SAMPLE  = 16'hfff8;
  localparam logic [15:0] INS_FLOAT   = 16'hffcf;
  localparam logic [15:0] INS_CLAMP   = 16'hffef;
  localparam logic [15:0] INS_BYPASS  = 16'hffff;
  // Capture pattern loaded into the instruction register (low bits 01)
  localparam logic [15:0] IR_CAPTURE  = 16'h0001;

  // ****************************************
  // Identification register layout
  // ****************************************
  localparam int          ID_VER_LSB  = 28;
  localparam int          ID_PART_LSB = 12;
  localparam int          ID_BANK_LSB = 8;
  localparam int          ID_MFR_LSB  = 1;
  localparam logic        ID_FIXED_ONE = 1'b1;

  // ****************************************
  // Sequencing counts
  // ****************************************
  localparam logic [2:0]  FORCE_RESET_PERIODS = 3'h5;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ST_RESET    = 4'h0, ST_IDLE     = 4'h1,
    ST_DR_SEL   = 4'h2, ST_DR_CAP   = 4'h3,
    ST_DR_SHIFT = 4'h4, ST_DR_EXIT1 = 4'h5,
    ST_DR_PAUSE = 4'h6, ST_DR_EXIT2 = 4'h7,
    ST_DR_UPD   = 4'h8, ST_IR_SEL   = 4'h9,
    ST_IR_CAP   = 4'ha, ST_IR_SHIFT = 4'hb,
    ST_IR_EXIT1 = 4'hc, ST_IR_PAUSE = 4'hd,
    ST_IR_EXIT2 = 4'he, ST_IR_UPD   = 4'hf
  } bst_state_t;

  // Selected serial path
  typedef enum logic [1:0] {
    PATH_BYPASS = 2'h0,
    PATH_IDENT  = 2'h1,
    PATH_CHAIN  = 2'h2
  } bst_path_t;

  // Test-clock edge events after sampling
  typedef struct packed {
    logic rise;
    logic fall;
    logic modeSel;
    logic dataIn;
  } bst_edge_t;

endpackage

//--- core/bst_pin_sync.sv
// Two-flop synchroniser and edge finder for the test-port pins
`timescale 1ns/1ps
`default_nettype none

module bst_pin_sync
  import bst_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_b,
  input  wire logic     tck,
  input  wire logic     tms,
  input  wire logic     tdi,
  input  wire logic     trst_b,
  output var bst_edge_t edges,
  output var logic      trstSync_b
);

  // ****************************************
  // Synchronisers
  // ****************************************
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic       tckOld_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // Idle pin levels: test reset, mode and data high, clock low,
      // so no false clock edge or test reset follows power-up reset
      meta_q <= 4'he;
      sync_q <= 4'he;
    end else begin
      meta_q <= {trst_b, tdi, tms, tck};
      sync_q <= meta_q;
    end
  end

  // Previous clock level for edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tckOld_q <= 1'b0;
    end else begin
      tckOld_q <= sync_q[0];
    end
  end

  assign edges.rise    = sync_q[0] & ~tckOld_q;
  assign edges.fall    = ~sync_q[0] & tckOld_q;
  assign edges.modeSel = sync_q[1];
  assign edges.dataIn  = sync_q[2];
  assign trstSync_b    = sync_q[3];

endmodule
`default_nettype wire

//--- bench/bst_tester.sv
// Behavioural test controller driving the scan port from the far side
`timescale 1ns/1ps
`default_nettype none

module bst_tester (
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi,
  input  wire logic tdo
);
  // ****************************************
  // Link sequencing
  // ****************************************
  // Test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One 80 ns period: inputs move after the fall, data out taken at the rise.
  // Long low phase because the port answers several system clocks late.
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #45;
    tck = 1'b1;
    q = tdo;
    #30;
    tck = 1'b0;
    #5;
  endtask

  // Five highs on both lines bring the controller home from any state
  task automatic home();
    logic q;
    for (int i = 0; i < 5; i++) begin
      step(1'b1, 1'b1, q);
    end
    step(1'b0, 1'b1, q);
  endtask

  // Full scan from idle back to idle, LSB first; update acts on the fall
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) begin
      step(1'b1, 1'b1, q);
    end
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule
`default_nettype wire

//--- bench/boundary_scan_tap_tb.sv
// Self-checking testbench of the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap_tb;
  import bst_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  localparam int          NC   = 8;
  localparam logic [3:0]  VER  = 4'h3;      // Arbitrary value
  localparam logic [15:0] PART = 16'h5a17;  // Arbitrary value
  localparam logic [3:0]  BANK = 4'h6;      // Arbitrary value
  localparam logic [7:0]  MFR  = 8'h9c;     // Arbitrary value

  logic            clk, rst_b, trst_b, tmsOpen, tdiOpen, tckOpen, q;
  wire logic       tck, tms, tdi;
  logic            tdo, tdoEn, testMode;
  logic [NC-1:0]   sysOut, sysOe, pinIn, pinOut, pinOe, coreIn;
  logic [31:0]     din, dout;
  logic [2*NC-1:0] hold;
  logic [15:0]     codes [7];
  int              failures, checks_done;

  bst_tap #(.NUM_CELLS(NC), .VERSION(VER), .PART_ID(PART), .MFR_BANK(BANK),
            .MFR_CODE(MFR)) DUT (
    .clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .trst_b(trst_b),
    .tmsOpen(tmsOpen), .tdiOpen(tdiOpen), .tckOpen(tckOpen), .tdo(tdo),
    .tdoEn(tdoEn), .sysOut(sysOut), .sysOe(sysOe), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .coreIn(coreIn), .testMode(testMode));

  // Data-out has no pull: while not enabled the tester sees the inverse
  bst_tester TST (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoEn ? tdo : ~tdo));

  // ****************************************
  // Expectations and checking
  // ****************************************
  function automatic logic [31:0] expId();
    return {VER, PART, BANK, MFR[6:0], ID_FIXED_ONE};
  endfunction

  // Scan length used for each instruction; bypass-path codes shift 8 bits
  function automatic int bits(input logic [15:0] c);
    if (c == INS_IDENT) return 32;
    if (c == INS_EXTEST || c == INS_SAMPLE) return 2 * NC;
    return 8;
  endfunction

  // Bypass shows its captured zero first, then the data one bit late
  function automatic logic [31:0] expScan(input logic [15:0] c);
    if (c == INS_IDENT) return expId();
    if (bits(c) == 2 * NC) return {16'h0, sysOe, pinIn};
    return {24'h0, din[6:0], 1'b0};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic scanDr(input logic [15:0] c);
    din = $urandom;
    TST.scan(1'b0, bits(c), din, dout);
  endtask

  task automatic scanIr(input logic [15:0] c);
    TST.scan(1'b1, 16, {16'h0, c}, dout);
    check(dout, 32'(IR_CAPTURE));
  endtask

  // Fresh core pin values, moved just after a system clock edge
  task automatic newSys();
    @(posedge clk);
    #1;
    sysOut = NC'($urandom);
    sysOe  = NC'($urandom);
    pinIn  = NC'($urandom);
  endtask

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    clk = 1'b0;
    forever begin
      #5 clk = ~clk;
    end
  end

  // Whole run takes well under 100 us; beyond 300 us it has hung
  initial begin
    #300000;
    failures++;
    test_done();
  end

  initial begin
    {rst_b, tmsOpen, tdiOpen, tckOpen} = 4'h0;
    trst_b = 1'b1;
    {sysOut, sysOe, pinIn} = '0;
    failures = 0;
    checks_done = 0;
    void'($urandom(32'hf3ab));
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    newSys();
    repeat (3) @(posedge clk);
    TST.step(1'b0, 1'b1, q);
    scanDr(INS_IDENT);
    check(dout, expScan(INS_IDENT));
    check(tdoEn, 1'b0);
    $display("test reset identity done");

    // Every code, with a random unknown one last
    codes = '{INS_EXTEST, INS_CLAMP, INS_SAMPLE, INS_FLOAT, INS_BYPASS, INS_IDENT, 16'h0};
    codes[6] = 16'($urandom) & 16'h7fff;
    hold = '0;
    foreach (codes[k]) begin
      newSys();
      scanIr(codes[k]);
      scanDr(codes[k]);
      check(dout, expScan(codes[k]));
      if (bits(codes[k]) == 2 * NC) begin
        hold = din[2*NC-1:0];
      end
      repeat (2) @(posedge clk);
      check(testMode, k < 2);
      if (k < 2) begin
        check(pinOut, hold[NC-1:0]);
        check(pinOe, hold[2*NC-1:NC]);
      end else begin
        check(pinOut, sysOut);
        check(pinOe, codes[k] == INS_FLOAT ? '0 : sysOe);
        check(coreIn, pinIn);
      end
      $display("test instruction %h done", codes[k]);
    end

    TST.home();
    scanDr(INS_IDENT);
    check(dout, expScan(INS_IDENT));
    $display("test forced reset done");

    // Floating clock reads low, so five highs must not reset
    scanIr(INS_BYPASS);
    @(posedge clk);
    #1 tckOpen = 1'b1;
    TST.home();
    #1 tckOpen = 1'b0;
    scanDr(INS_BYPASS);
    check(dout, expScan(INS_BYPASS));
    {tmsOpen, tdiOpen} = 2'h3;
    for (int i = 0; i < 5; i++) begin
      TST.step(1'b0, 1'b0, q);
    end
    {tmsOpen, tdiOpen} = 2'h0;
    TST.step(1'b0, 1'b1, q);
    scanDr(INS_IDENT);
    check(dout, expScan(INS_IDENT));
    $display("test open pins done");

    scanIr(INS_EXTEST);
    scanDr(INS_EXTEST);
    newSys();
    trst_b = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check(testMode, 1'b0);
    check(pinOut, sysOut);
    check(pinOe, sysOe);
    #1 trst_b = 1'b1;
    repeat (4) @(posedge clk);
    TST.step(1'b0, 1'b1, q);
    scanDr(INS_IDENT);
    check(dout, expScan(INS_IDENT));
    $display("test test reset done");
    test_done();
  end
endmodule
`default_nettype wire
